// ==== design/cswm_pkg.sv ====
// Constants shared by the cyclic sense and wake manager.
package cswm_pkg;
   // Byte addresses of the registers (low eight address bits).
   localparam logic [7:0] ADDR_SETTINGS = 8'h20;
   localparam logic [7:0] ADDR_SENSE_DT = 8'h28;
   localparam logic [7:0] ADDR_WAKE_DT = 8'h2c;
   localparam logic [7:0] ADDR_SAMPLE = 8'h30;
   localparam logic [7:0] ADDR_P1_STS = 8'h8c;
   localparam logic [7:0] ADDR_SEL0 = 8'h40;
   localparam logic [7:0] ADDR_SEL1 = 8'h44;
   localparam logic [7:0] ADDR_CTRL = 8'h48;
   localparam logic [7:0] ADDR_STATE = 8'h4c;
   localparam logic [7:0] ADDR_IRQ_STS = 8'h50;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h54;
   // Reset values.
   localparam logic [7:0] RST_SETTINGS = 8'h04;
   localparam logic [7:0] RST_SENSE_DT = 8'h00;
   localparam logic [7:0] RST_WAKE_DT = 8'h37;
   localparam logic [7:0] RST_SAMPLE = 8'h00;
   // Writable bits; the others are reserved and read zero.
   localparam logic [7:0] WM_SETTINGS = 8'h8f;
   localparam logic [7:0] WM_SENSE_DT = 8'hbf;
   localparam logic [7:0] WM_WAKE_DT = 8'h3f;
   // Field positions.
   localparam int SET_SENSE_EN = 3;
   localparam int SET_WAKE_EN = 2;
   localparam int EXP_MSB = 5;
   localparam int EXP_LSB = 4;
   localparam int MAN_MSB = 3;
   localparam int CTRL_SLEEP = 0;
   localparam int CTRL_HOLD = 1;
   localparam int IRQ_SENSE = 0;
   localparam int IRQ_WAKE = 1;
   localparam int IRQ_P1 = 2;
   localparam int IRQ_W = 3;
   localparam int PIN_COUNT = 5;
   localparam int CNT_W = 11;
   // Low-power tick: one dead-time unit of 2 ms at a 10 ns clock.
   localparam int unsigned DEAD_UNIT_NS = 2000000;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned TICK_CYCLES = DEAD_UNIT_NS / CLK_PERIOD_NS;
   // Sequencer states.
   typedef enum logic [2:0] {
      ST_ACTIVE = 3'b000,
      ST_DEAD = 3'b001,
      ST_SENSE = 3'b010,
      ST_SLEEP = 3'b011,
      ST_STARTUP = 3'b100
   } cswm_state_t;
endpackage : cswm_pkg

// ==== design/cswm_top.sv ====
// Cyclic sense and cyclic wake sequencer with its AHB-Lite registers.
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/10ps

// Behaviour
// - port-1 flags set on wake, cleared by read.
// - dead, sample and wake timing runs on low-power tick.
// - pin senses only when select bit set.
// - wake info accepted only while supply on.
// - dead time and sample delay from registers.
// - evaluate source after sample delay elapses.
// - unchanged sample returns to dead time.
// - changed sample produces a wake-up.
// - sense wake runs normal startup automatically.
// - supply stays on until software clears it.
// - every port-0 and port-1 pin selectable.
// - cyclic wake after interval, startup, active.
// - wake interval from wake dead-time register.
// - configuration registers at fixed word offsets.
// - dead time is four-power times mantissa plus one.
// - sense enable checked on entry and in dead time, not in the sense phase.
// - wake runs only when its enable set.
module cswm_top #(
   parameter int unsigned TICK_CYCLES = cswm_pkg::TICK_CYCLES
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [cswm_pkg::PIN_COUNT-1:0] port0_wake_in,
   input wire logic [cswm_pkg::PIN_COUNT-1:0] port1_wake_in,
   output logic sensor_supply_gate,
   output logic low_power_mode,
   output logic startup_pulse,
   output logic irq
);

   localparam int PW = 2 * cswm_pkg::PIN_COUNT;
   localparam int NP = cswm_pkg::PIN_COUNT;
   localparam int CW = cswm_pkg::CNT_W;

   // Dead time in ticks: four to the exponent times mantissa plus one.
   function automatic logic [CW-1:0] dead_len(input logic [7:0] v);
      logic [CW-1:0] man;
      man = {7'h00, v[cswm_pkg::MAN_MSB:0]} + 11'h001;
      return man << {v[cswm_pkg::EXP_MSB:cswm_pkg::EXP_LSB], 1'b0};
   endfunction : dead_len

   // Registers seen by software.
   logic [7:0] settings_reg;
   logic [7:0] sense_dt_reg;
   logic [7:0] wake_dt_reg;
   logic [7:0] sample_reg;
   logic [NP-1:0] sel0_reg;
   logic [NP-1:0] sel1_reg;
   logic sleep_reg;
   logic hold_reg;
   logic [NP-1:0] p1_flags_reg;
   logic [cswm_pkg::IRQ_W-1:0] irq_sts_reg;
   logic [cswm_pkg::IRQ_W-1:0] irq_mask_reg;
   // Bus pipeline state.
   logic wr_pend_reg;
   logic rd_pend_reg;
   logic [7:0] addr_reg;
   logic [31:0] hrdata_reg;
   logic hreadyout_reg;
   logic hresp_reg;
   // Sequencer state.
   cswm_pkg::cswm_state_t state_reg;
   cswm_pkg::cswm_state_t state_next;
   logic [31:0] tick_cnt_reg;
   logic lp_tick_reg;
   logic [CW-1:0] seq_cnt_reg;
   logic [CW-1:0] wake_cnt_reg;
   logic [PW-1:0] prev_reg;
   // Output flops.
   logic gate_reg;
   logic lp_mode_reg;
   logic startup_reg;
   logic irq_reg;

   // Decoded events.
   logic addr_ok;
   logic wr_now;
   logic rd_p1;
   logic sense_en;
   logic wake_en;
   logic in_lp;
   logic seq_done;
   logic eval;
   logic [PW-1:0] diff;
   logic sense_wake;
   logic wake_fire;
   logic enter_lp;
   logic [CW-1:0] seq_len;

   assign addr_ok = hsel && hready && htrans[1];
   assign wr_now = wr_pend_reg;
   assign rd_p1 = rd_pend_reg && (addr_reg == cswm_pkg::ADDR_P1_STS);
   assign sense_en = settings_reg[cswm_pkg::SET_SENSE_EN];
   assign wake_en = settings_reg[cswm_pkg::SET_WAKE_EN];
   assign in_lp = (state_reg == cswm_pkg::ST_DEAD)
      || (state_reg == cswm_pkg::ST_SENSE)
      || (state_reg == cswm_pkg::ST_SLEEP);
   assign enter_lp = (state_reg == cswm_pkg::ST_ACTIVE) && sleep_reg;

   // dead time or sample delay per phase.
   assign seq_len = (state_reg == cswm_pkg::ST_SENSE)
      ? ({3'h0, sample_reg} + 11'h001) : dead_len(sense_dt_reg);
   assign seq_done = lp_tick_reg && (seq_cnt_reg == seq_len - 11'h001);

   // evaluate at the end of the sample delay.
   assign eval = (state_reg == cswm_pkg::ST_SENSE) && seq_done;
   assign diff = ({port1_wake_in, port0_wake_in} ^ prev_reg)
      & {sel1_reg, sel0_reg};
   assign sense_wake = eval && (|diff);
   assign wake_fire = in_lp && wake_en && lp_tick_reg
      && (wake_cnt_reg == dead_len(wake_dt_reg) - 11'h001);

   // Free-running divider making the low-power clock enable.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         tick_cnt_reg <= 32'h0000_0000;
         lp_tick_reg <= 1'b0;
      end
      else if (tick_cnt_reg >= TICK_CYCLES - 32'h1)
      begin
         tick_cnt_reg <= 32'h0000_0000;
         lp_tick_reg <= 1'b1;
      end
      else
      begin
         tick_cnt_reg <= tick_cnt_reg + 32'h1;
         lp_tick_reg <= 1'b0;
      end
   end

   // Next state of the sequencer.
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         cswm_pkg::ST_ACTIVE:
         begin
            if (enter_lp)
               state_next = sense_en ? cswm_pkg::ST_DEAD
                  : cswm_pkg::ST_SLEEP;
         end
         cswm_pkg::ST_DEAD:
         begin
            if (wake_fire)
               state_next = cswm_pkg::ST_STARTUP;
            else if (!sense_en)
               state_next = cswm_pkg::ST_SLEEP;
            else if (seq_done)
               state_next = cswm_pkg::ST_SENSE;
         end
         cswm_pkg::ST_SENSE:
         begin
            // no change goes back to dead time.
            if (wake_fire || sense_wake)
               state_next = cswm_pkg::ST_STARTUP;
            else if (eval)
               state_next = cswm_pkg::ST_DEAD;
         end
         cswm_pkg::ST_SLEEP:
         begin
            // timed wake from sleep.
            if (wake_fire)
               state_next = cswm_pkg::ST_STARTUP;
         end
         cswm_pkg::ST_STARTUP:
         begin
            state_next = cswm_pkg::ST_ACTIVE;
         end
         default:
         begin
            state_next = cswm_pkg::ST_ACTIVE;
         end
      endcase
   end

   // State register.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         state_reg <= cswm_pkg::ST_ACTIVE;
      else
         state_reg <= state_next;
   end

   // Phase counter for dead time and sample delay.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         seq_cnt_reg <= '0;
      else if (state_next != state_reg)
         seq_cnt_reg <= '0;
      else if (lp_tick_reg)
         seq_cnt_reg <= seq_cnt_reg + 11'h001;
   end

   // Cyclic wake interval counter, runs through all low-power phases.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         wake_cnt_reg <= '0;
      else if (!in_lp || wake_fire)
         wake_cnt_reg <= '0;
      else if (lp_tick_reg)
         wake_cnt_reg <= wake_cnt_reg + 11'h001;
   end

   // Previous pin samples, taken on entry and at each evaluation.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         prev_reg <= '0;
      else if (enter_lp || eval)
         prev_reg <= {port1_wake_in, port0_wake_in};
   end

   // Bus address phase capture; reads take one wait state.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         addr_reg <= 8'h00;
         hreadyout_reg <= 1'b1;
      end
      else
      begin
         wr_pend_reg <= addr_ok && hwrite;
         rd_pend_reg <= addr_ok && !hwrite;
         hreadyout_reg <= !(addr_ok && !hwrite);
         if (addr_ok)
            addr_reg <= haddr[7:0];
      end
   end

   // Read data mux, loaded at the end of the wait state.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata_reg <= 32'h0000_0000;
      else if (rd_pend_reg)
      begin
         case (addr_reg)
            cswm_pkg::ADDR_SETTINGS: hrdata_reg <= {24'h0, settings_reg};
            cswm_pkg::ADDR_SENSE_DT: hrdata_reg <= {24'h0, sense_dt_reg};
            cswm_pkg::ADDR_WAKE_DT: hrdata_reg <= {24'h0, wake_dt_reg};
            cswm_pkg::ADDR_SAMPLE: hrdata_reg <= {24'h0, sample_reg};
            cswm_pkg::ADDR_P1_STS: hrdata_reg <= {27'h0, p1_flags_reg};
            cswm_pkg::ADDR_SEL0: hrdata_reg <= {27'h0, sel0_reg};
            cswm_pkg::ADDR_SEL1: hrdata_reg <= {27'h0, sel1_reg};
            cswm_pkg::ADDR_CTRL: hrdata_reg <= {30'h0, hold_reg, sleep_reg};
            cswm_pkg::ADDR_STATE: hrdata_reg <= {29'h0, state_reg};
            cswm_pkg::ADDR_IRQ_STS: hrdata_reg <= {29'h0, irq_sts_reg};
            cswm_pkg::ADDR_IRQ_MASK: hrdata_reg <= {29'h0, irq_mask_reg};
            default: hrdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   // Response is always OKAY.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hresp_reg <= 1'b0;
      else
         hresp_reg <= 1'b0;
   end

   // Configuration registers written in the data phase.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         settings_reg <= cswm_pkg::RST_SETTINGS;
         sense_dt_reg <= cswm_pkg::RST_SENSE_DT;
         wake_dt_reg <= cswm_pkg::RST_WAKE_DT;
         sample_reg <= cswm_pkg::RST_SAMPLE;
         sel0_reg <= '0;
         sel1_reg <= '0;
         irq_mask_reg <= '0;
      end
      else if (wr_now)
      begin
         case (addr_reg)
            cswm_pkg::ADDR_SETTINGS:
               settings_reg <= hwdata[7:0] & cswm_pkg::WM_SETTINGS;
            cswm_pkg::ADDR_SENSE_DT:
               sense_dt_reg <= hwdata[7:0] & cswm_pkg::WM_SENSE_DT;
            cswm_pkg::ADDR_WAKE_DT:
               wake_dt_reg <= hwdata[7:0] & cswm_pkg::WM_WAKE_DT;
            cswm_pkg::ADDR_SAMPLE: sample_reg <= hwdata[7:0];
            cswm_pkg::ADDR_SEL0: sel0_reg <= hwdata[NP-1:0];
            cswm_pkg::ADDR_SEL1: sel1_reg <= hwdata[NP-1:0];
            cswm_pkg::ADDR_IRQ_MASK:
               irq_mask_reg <= hwdata[cswm_pkg::IRQ_W-1:0];
            default: sel0_reg <= sel0_reg;
         endcase
      end
   end

   // Sleep request: software sets it, the startup phase clears it.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         sleep_reg <= 1'b0;
      else if (state_reg == cswm_pkg::ST_STARTUP)
         sleep_reg <= 1'b0;
      else if (wr_now && addr_reg == cswm_pkg::ADDR_CTRL)
         sleep_reg <= hwdata[cswm_pkg::CTRL_SLEEP];
   end

   // Supply hold: set by a sense wake, cleared only by software.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hold_reg <= 1'b0;
      else if (sense_wake)
         hold_reg <= 1'b1;
      else if (wr_now && addr_reg == cswm_pkg::ADDR_CTRL)
         hold_reg <= hwdata[cswm_pkg::CTRL_HOLD];
   end

   // Port-1 wake flags; a new wake wins over the clearing read.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         p1_flags_reg <= '0;
      // set on wake, clear on read.
      else if (rd_p1)
         p1_flags_reg <= sense_wake ? diff[PW-1:NP] : '0;
      else if (sense_wake)
         p1_flags_reg <= p1_flags_reg | diff[PW-1:NP];
   end

   // Sticky interrupt status, write one to clear, set wins.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         irq_sts_reg <= '0;
      else
      begin
         for (int i = 0; i < cswm_pkg::IRQ_W; i++)
         begin
            if ((i == cswm_pkg::IRQ_SENSE && sense_wake)
               || (i == cswm_pkg::IRQ_WAKE && wake_fire)
               || (i == cswm_pkg::IRQ_P1 && sense_wake
                  && (|diff[PW-1:NP])))
               irq_sts_reg[i] <= 1'b1;
            else if (wr_now && addr_reg == cswm_pkg::ADDR_IRQ_STS
               && hwdata[i])
               irq_sts_reg[i] <= 1'b0;
         end
      end
   end

   // Registered outputs.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         gate_reg <= 1'b0;
         lp_mode_reg <= 1'b0;
         startup_reg <= 1'b0;
         irq_reg <= 1'b0;
      end
      else
      begin
         gate_reg <= (state_reg == cswm_pkg::ST_SENSE) || hold_reg;
         lp_mode_reg <= in_lp;
         startup_reg <= (state_reg == cswm_pkg::ST_STARTUP);
         irq_reg <= |(irq_sts_reg & irq_mask_reg);
      end
   end

   assign hrdata = hrdata_reg;
   assign hreadyout = hreadyout_reg;
   assign hresp = hresp_reg;
   assign sensor_supply_gate = gate_reg;
   assign low_power_mode = lp_mode_reg;
   assign startup_pulse = startup_reg;
   assign irq = irq_reg;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // Reserved status bits read zero.
   a_p1_rsvd_zero: assert property (rd_p1 |=> hrdata[31:NP] == '0)
      else $error("Port-1 status reserved bits not zero.");
   // A read clears the flags unless a new wake arrives.
   a_p1_read_clr: assert property (
      rd_p1 && !sense_wake |=> p1_flags_reg == '0)
      else $error("Port-1 flags not cleared by read.");
   // Dead phase moves to sensing only on a tick.
   a_dead_tick: assert property (
      state_reg == cswm_pkg::ST_DEAD && state_next == cswm_pkg::ST_SENSE
      |-> lp_tick_reg)
      else $error("Sense phase began without a tick.");
   // Supply gate follows the sensing phase.
   a_gate_sense: assert property (
      state_reg == cswm_pkg::ST_SENSE |=> sensor_supply_gate)
      else $error("Supply gate off while sensing.");
   // Unchanged sample returns to dead time.
   a_same_back: assert property (
      eval && !(|diff) && !wake_fire |=> state_reg == cswm_pkg::ST_DEAD)
      else $error("No return to dead time.");
   // Changed sample starts up then goes active with a pulse.
   a_diff_wake: assert property (
      sense_wake |=> state_reg == cswm_pkg::ST_STARTUP
      ##1 (state_reg == cswm_pkg::ST_ACTIVE && startup_pulse))
      else $error("Sense wake did not start up.");
   // Supply stays on after a sense wake.
   a_hold_kept: assert property (
      sense_wake |=> ##1 sensor_supply_gate [*3])
      else $error("Supply dropped after sense wake.");
   // Disabled sense goes from active to sleep, not to dead time.
   a_sense_off: assert property (
      enter_lp && !sense_en |=> state_reg == cswm_pkg::ST_SLEEP)
      else $error("Sense ran while disabled.");
   // Wake interval expiry starts up.
   a_wake_fire: assert property (
      wake_fire |=> state_reg == cswm_pkg::ST_STARTUP)
      else $error("Cyclic wake missed.");
   // Disabled cyclic wake never fires.
   a_wake_off: assert property (
      !wake_en |-> !wake_fire)
      else $error("Wake fired while disabled.");

endmodule : cswm_top

// ==== verif/cswm_pins.sv ====
// Model of the wake pins and the switch sensors that hang on them.
`timescale 1ns/10ps
module cswm_pins (
   input wire logic hclk,
   input wire logic sensor_supply_gate,
   input wire logic low_power_mode,
   input wire logic noise,
   input wire logic [4:0] level0,
   input wire logic [4:0] level1,
   output logic [4:0] port0_wake_in,
   output logic [4:0] port1_wake_in
);
   // Pattern that a floating line shows; it changes every cycle.
   logic [4:0] pat = 5'h00;
   // High in low-power mode while the sensors are unpowered and asked to float.
   logic loose;
   // Unpowered sensors give no stable level, so the lines wander.
   // unpowered lines wander.
   assign loose = noise & low_power_mode & ~sensor_supply_gate;
   // Step the floating pattern.
   always @(posedge hclk)
   begin
      pat <= pat + 5'h0b;
   end
   // Powered sensors show the switch levels set by the bench.
   assign port0_wake_in = loose ? ~level0 ^ pat : level0;
   assign port1_wake_in = loose ? ~level1 ^ pat : level1;
endmodule : cswm_pins

// ==== verif/tb.sv ====
// Self-checking bench for the cyclic sense and wake manager.
`timescale 1ns/10ps
module tb;
   localparam int unsigned TK = 4; // Shortened low-power tick.
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0] htrans = '0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = '0;
   logic [4:0] sw0 = 5'h00; // Switch levels on port 0.
   logic [4:0] sw1 = 5'h00; // Switch levels on port 1.
   logic noise = 1'b0; // Lets unpowered lines float.
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic gate;
   logic lpm;
   logic start_p;
   logic irq;
   logic [4:0] p0;
   logic [4:0] p1;
   logic [31:0] seed = 32'h0000000c;
   int fail_count = 0;
   int comparisons = 0;

   cswm_top #(.TICK_CYCLES(TK)) i_cswm_top (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .port0_wake_in(p0), .port1_wake_in(p1),
      .sensor_supply_gate(gate), .low_power_mode(lpm),
      .startup_pulse(start_p), .irq(irq));

   cswm_pins i_cswm_pins (
      .hclk(hclk), .sensor_supply_gate(gate), .low_power_mode(lpm),
      .noise(noise), .level0(sw0), .level1(sw1),
      .port0_wake_in(p0), .port1_wake_in(p1));

   // Free-running 100 MHz clock.
   initial
   begin
      forever #5 hclk = ~hclk;
   end

   // Repeatable xorshift source.
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // Dead time in ticks from the exponent and mantissa fields.
   function automatic int dead(input logic [31:0] v);
      return (1 << (2 * int'(v[5:4]))) * (int'(v[3:0]) + 1);
   endfunction : dead

   // Conditions that wait_for can look for.
   function automatic logic cond(input int s);
      case (s)
         0: cond = (gate === 1'b1);
         1: cond = (gate === 1'b0);
         2: cond = (start_p === 1'b1);
         default: cond = (lpm === 1'b1);
      endcase
   endfunction : cond

   // Prints the verdict and ends the run.
   task automatic final_report();
      if (fail_count == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : final_report

   // Compares two words exactly.
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         $display("FAIL %0t got %h want %h", $time, got, exp);
         fail_count++;
      end
   endtask : check

   // Compares one design flag.
   task automatic flag(input logic got, input logic exp);
      check({31'h0, got}, {31'h0, exp});
   endtask : flag

   // Compares a measured cycle count against a window.
   task automatic near(input int got, input int exp, input int tol);
      comparisons++;
      if (got < exp - tol || got > exp + tol)
      begin
         $display("FAIL %0t count %0d want %0d", $time, got, exp);
         fail_count++;
      end
   endtask : near

   // Counts edges until a condition holds; -1 if it never does.
   task automatic wait_for(input int s, input int lim, output int n);
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (!cond(s) && n < lim);
      if (!cond(s))
         n = -1;
   endtask : wait_for

   // One single AHB-Lite transfer; waits on hready in both phases.
   task automatic bus(input logic [7:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(a, 1'b1, d, r);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] r;
      bus(a, 1'b0, 32'h0, r);
      check(r, {24'h0, e});
   endtask : rd_chk

   // Cuts a hung run short.
   initial
   begin
      #400000;
      fail_count++;
      final_report();
   end

   // Main sequence.
   initial
   begin
      int n;
      int h;
      logic [31:0] q;
      logic [31:0] s;
      logic [31:0] m;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      // Reset values, reserved bits and an unmapped word.
      rd_chk(cswm_pkg::ADDR_SETTINGS, cswm_pkg::RST_SETTINGS);
      rd_chk(cswm_pkg::ADDR_SENSE_DT, cswm_pkg::RST_SENSE_DT);
      rd_chk(cswm_pkg::ADDR_WAKE_DT, cswm_pkg::RST_WAKE_DT);
      rd_chk(cswm_pkg::ADDR_SAMPLE, cswm_pkg::RST_SAMPLE);
      wr(cswm_pkg::ADDR_P1_STS, 32'hffffffff);
      rd_chk(cswm_pkg::ADDR_P1_STS, 8'h00);
      wr(cswm_pkg::ADDR_SENSE_DT, 32'hffffffff);
      rd_chk(cswm_pkg::ADDR_SENSE_DT, cswm_pkg::WM_SENSE_DT);
      wr(cswm_pkg::ADDR_WAKE_DT, 32'hffffffff);
      rd_chk(cswm_pkg::ADDR_WAKE_DT, cswm_pkg::WM_WAKE_DT);
      wr(8'h10, 32'hffffffff);
      rd_chk(8'h10, 8'h00);
      flag(hresp, 1'b0);
      // Cyclic sense wake from each pin of both ports in turn.
      for (int i = 0; i < 10; i++)
      begin
         q = 32'h1 << i;
         s = rnd() & 32'h13;
         m = rnd() & 32'h1;
         wr(cswm_pkg::ADDR_SETTINGS, 32'h08);
         wr(cswm_pkg::ADDR_SENSE_DT, s);
         wr(cswm_pkg::ADDR_SAMPLE, m);
         wr(cswm_pkg::ADDR_SEL0, q & 32'h1f);
         wr(cswm_pkg::ADDR_SEL1, q >> 5);
         wr(cswm_pkg::ADDR_IRQ_MASK, 32'h3);
         noise <= 1'b1;
         wr(cswm_pkg::ADDR_CTRL, 32'h1);
         wait_for(3, 20, n);
         flag(n < 0, 1'b0);
         wait_for(0, 400, n);
         flag(n < 0, 1'b0);
         // Pins that are not selected move; no wake may follow.
         {sw1, sw0} <= {sw1, sw0} ^ ~q[9:0];
         wait_for(1, 400, h);
         near(h, (int'(m) + 1) * TK, 1);
         wait_for(0, 400, n);
         near(n, dead(s) * TK, 1);
         flag(lpm, 1'b1);
         // The selected pin changes during sensing.
         {sw1, sw0} <= {sw1, sw0} ^ q[9:0];
         wait_for(2, (int'(m) + 1) * TK + 6, n);
         flag(n < 0, 1'b0);
         repeat (2) @(posedge hclk);
         flag(gate, 1'b1);
         flag(irq, 1'b1);
         rd_chk(cswm_pkg::ADDR_P1_STS, q[12:5]);
         rd_chk(cswm_pkg::ADDR_P1_STS, 8'h00);
         rd_chk(cswm_pkg::ADDR_STATE, {5'h0, cswm_pkg::ST_ACTIVE});
         wr(cswm_pkg::ADDR_IRQ_MASK, 32'h0);
         repeat (2) @(posedge hclk);
         flag(irq, 1'b0);
         wr(cswm_pkg::ADDR_IRQ_MASK, 32'h3);
         wr(cswm_pkg::ADDR_IRQ_STS, 32'h7);
         repeat (2) @(posedge hclk);
         flag(irq, 1'b0);
         wr(cswm_pkg::ADDR_CTRL, 32'h0);
         repeat (2) @(posedge hclk);
         flag(gate, 1'b0);
         noise <= 1'b0;
      end
      // Cyclic wake after the programmed interval.
      for (int i = 0; i < 3; i++)
      begin
         s = rnd() & 32'h13;
         wr(cswm_pkg::ADDR_SETTINGS, 32'h04);
         wr(cswm_pkg::ADDR_WAKE_DT, s);
         wr(cswm_pkg::ADDR_CTRL, 32'h1);
         wait_for(3, 20, n);
         flag(n < 0, 1'b0);
         wait_for(2, dead(s) * TK + 20, n);
         near(n, dead(s) * TK, TK + 2);
         flag(gate, 1'b0);
         rd_chk(cswm_pkg::ADDR_IRQ_STS, 8'h02);
         wr(cswm_pkg::ADDR_IRQ_STS, 32'h2);
      end
      // Both features off: pin changes and time bring no wake.
      wr(cswm_pkg::ADDR_SETTINGS, 32'h00);
      wr(cswm_pkg::ADDR_SEL1, 32'h1f);
      wr(cswm_pkg::ADDR_CTRL, 32'h1);
      wait_for(3, 20, n);
      flag(n < 0, 1'b0);
      sw1 <= ~sw1;
      wait_for(2, 500, n);
      flag(n < 0, 1'b1);
      flag(gate, 1'b0);
      rd_chk(cswm_pkg::ADDR_STATE, {5'h0, cswm_pkg::ST_SLEEP});
      // A second reset brings back the defaults.
      hresetn <= 1'b0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      rd_chk(cswm_pkg::ADDR_SETTINGS, cswm_pkg::RST_SETTINGS);
      flag(lpm, 1'b0);
      final_report();
   end
endmodule : tb
